// ===== cqt_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cqt_asserts #(
  parameter int ADDR_W = 23
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic chip_en_n_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [15:0] dq_i,
  input wire logic [15:0] array_data_i,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_o,
  input wire logic query_mode_o
);
  logic we_q;
  logic rd;
  logic wr;
  // Edge detect so a held strobe counts once
  always_ff @(posedge clk_i) we_q <= rst_i ? 1'b1 : write_en_n_i;
  assign rd = !chip_en_n_i && !out_en_n_i && write_en_n_i;
  assign wr = !chip_en_n_i && !write_en_n_i && we_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(o);
    query_mode_o && rd && addr_i[7:0] == o;
  endsequence
  sequence s_wr(c);
    wr && dq_i[7:0] == c;
  endsequence
  AST_OE: assert property (1 |=> dq_oe_o == $past(rd))
    else $error("oe mismatch");
  AST_ARR: assert property (!query_mode_o && rd |=>
    dq_o == $past(array_data_i)) else $error("array data wrong");
  AST_UP: assert property (query_mode_o && rd |=> dq_o[15:8] == 8'h00)
    else $error("upper byte set");
  AST_SIG: assert property (s_rd(8'h12) |=> dq_o == 16'h0059)
    else $error("Y char wrong");
  AST_PTR: assert property (s_rd(8'h16) |=> dq_o == 16'h0001)
    else $error("pointer high wrong");
  AST_VEND: assert property (query_mode_o && rd && addr_i[7:4] == 4'h0
    |=> dq_o == 16'h0000) else $error("vendor area not zero");
  AST_ENT: assert property (s_wr(8'h98) |=> query_mode_o)
    else $error("query not entered");
  AST_EXIT: assert property (s_wr(8'hff) |=> !query_mode_o)
    else $error("query not left");
  AST_KEEP: assert property (wr && dq_i[7:0] != 8'h98 &&
    dq_i[7:0] != 8'hff |=> $stable(query_mode_o)) else $error("mode moved");
endmodule : cqt_asserts
bind cqt_query_table_rom cqt_asserts #(.ADDR_W(ADDR_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .chip_en_n_i(chip_en_n_i),
  .out_en_n_i(out_en_n_i), .write_en_n_i(write_en_n_i), .addr_i(addr_i),
  .dq_i(dq_i), .array_data_i(array_data_i), .dq_o(dq_o),
  .dq_oe_o(dq_oe_o), .query_mode_o(query_mode_o));
`default_nettype wire

// ===== cqt_host.sv
`timescale 1ns/100ps
`default_nettype none
module cqt_host (
  // Clock and read data
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  // Bus strobes and lines
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [22:0] addr_o,
  output logic [15:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = '0;
    wdata_o = '0;
  end
  // One write cycle; released lines flip so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] c);
    @(posedge clk_i);
    #1;
    {ce_n_o, we_n_o, addr_o, wdata_o} = {2'b00, 15'h0000, a, 8'h00, c};
    @(posedge clk_i);
    #1;
    {ce_n_o, we_n_o, addr_o, wdata_o} = {2'b11, ~addr_o, ~wdata_o};
  endtask : wr
  // One read cycle, data taken just after the edge that samples it
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    {ce_n_o, oe_n_o, addr_o} = {2'b00, 15'h0000, a};
    @(posedge clk_i);
    #1;
    d = rdata_i;
    {ce_n_o, oe_n_o, addr_o} = {2'b11, ~addr_o};
  endtask : rd
endmodule : cqt_host
`default_nettype wire

// ===== cqt_pkg.sv
`default_nettype none
package cqt_pkg;
  // Bus widths
  localparam int CQT_DATA_W = 16;
  localparam int CQT_ADDR_W = 23;
  localparam int CQT_OFS_W = 8;

  // Bus command codes
  localparam logic [7:0] CQT_CMD_QUERY = 8'h98;
  localparam logic [7:0] CQT_CMD_READ_ARRAY = 8'hff;

  // Section map
  localparam logic [7:0] CQT_VENDOR_FIRST_OFS = 8'h01;
  localparam logic [7:0] CQT_VENDOR_LAST_OFS = 8'h0f;
  localparam logic [7:0] CQT_IDENT_SECT_OFS = 8'h10;
  localparam logic [7:0] CQT_SYSIF_SECT_OFS = 8'h1b;
  localparam logic [7:0] CQT_GEOM_SECT_OFS = 8'h27;

  // Identification string section
  localparam logic [7:0] QUERY_SIG_CHAR_Q_OFS = 8'h10;
  localparam logic [7:0] QUERY_SIG_CHAR_R_OFS = 8'h11;
  localparam logic [7:0] QUERY_SIG_CHAR_Y_OFS = 8'h12;
  localparam logic [7:0] PRIMARY_CMDSET_CODE_LO_OFS = 8'h13;
  localparam logic [7:0] PRIMARY_CMDSET_CODE_HI_OFS = 8'h14;
  localparam logic [7:0] EXT_TABLE_ADDR_LO_OFS = 8'h15;
  localparam logic [7:0] EXT_TABLE_ADDR_HI_OFS = 8'h16;
  localparam logic [7:0] ALT_CMDSET_CODE_LO_OFS = 8'h17;
  localparam logic [7:0] ALT_CMDSET_CODE_HI_OFS = 8'h18;
  localparam logic [7:0] SECOND_TABLE_ADDR_LO_OFS = 8'h19;
  localparam logic [7:0] SECOND_TABLE_ADDR_HI_OFS = 8'h1a;

  // System interface section
  localparam logic [7:0] CORE_SUPPLY_MIN_VOLT_OFS = 8'h1b;
  localparam logic [7:0] CORE_SUPPLY_MAX_VOLT_OFS = 8'h1c;
  localparam logic [7:0] PROG_SUPPLY_MIN_VOLT_OFS = 8'h1d;
  localparam logic [7:0] PROG_SUPPLY_MAX_VOLT_OFS = 8'h1e;
  localparam logic [7:0] TYP_WORD_PROG_EXP_OFS = 8'h1f;
  localparam logic [7:0] TYP_BUFFER_WRITE_EXP_OFS = 8'h20;
  localparam logic [7:0] TYP_BLOCK_ERASE_EXP_OFS = 8'h21;
  localparam logic [7:0] TYP_CHIP_ERASE_EXP_OFS = 8'h22;
  localparam logic [7:0] MAX_WORD_PROG_EXP_OFS = 8'h23;
  localparam logic [7:0] MAX_BUFFER_WRITE_EXP_OFS = 8'h24;
  localparam logic [7:0] MAX_BLOCK_ERASE_EXP_OFS = 8'h25;
  localparam logic [7:0] MAX_CHIP_ERASE_EXP_OFS = 8'h26;

  // Table contents
  localparam logic [7:0] QUERY_SIG_CHAR_Q_VAL = 8'h51;
  localparam logic [7:0] QUERY_SIG_CHAR_R_VAL = 8'h52;
  localparam logic [7:0] QUERY_SIG_CHAR_Y_VAL = 8'h59;
  localparam logic [7:0] EXT_TABLE_ADDR_LO_VAL = 8'h0a;
  localparam logic [7:0] EXT_TABLE_ADDR_HI_VAL = 8'h01;
  localparam logic [7:0] ALT_CMDSET_CODE_LO_VAL = 8'h00;
  localparam logic [7:0] ALT_CMDSET_CODE_HI_VAL = 8'h00;
  localparam logic [7:0] SECOND_TABLE_ADDR_LO_VAL = 8'h00;
  localparam logic [7:0] SECOND_TABLE_ADDR_HI_VAL = 8'h00;
  localparam logic [7:0] CORE_SUPPLY_MIN_VOLT_VAL = 8'h17;
  localparam logic [7:0] CORE_SUPPLY_MAX_VOLT_VAL = 8'h20;
  localparam logic [7:0] PROG_SUPPLY_MIN_VOLT_VAL = 8'h85;
  localparam logic [7:0] PROG_SUPPLY_MAX_VOLT_VAL = 8'h95;
  localparam logic [7:0] TYP_WORD_PROG_EXP_VAL = 8'h08;
  localparam logic [7:0] TYP_BUFFER_WRITE_EXP_VAL = 8'h09;
  localparam logic [7:0] TYP_BLOCK_ERASE_EXP_VAL = 8'h0a;
  localparam logic [7:0] TYP_CHIP_ERASE_EXP_VAL = 8'h00;
  localparam logic [7:0] MAX_WORD_PROG_EXP_VAL = 8'h01;
  localparam logic [7:0] MAX_BUFFER_WRITE_EXP_VAL = 8'h01;
  localparam logic [7:0] MAX_BLOCK_ERASE_EXP_VAL = 8'h02;
  localparam logic [7:0] MAX_CHIP_ERASE_EXP_VAL = 8'h00;
  localparam logic [7:0] CQT_UNUSED_VAL = 8'h00;
  localparam logic [7:0] CQT_UPPER_BYTE_VAL = 8'h00;

  // Arbitrary neutral value for the command-set identity code
  localparam logic [15:0] CQT_CMDSET_CODE_DEFAULT = 16'h5a3c;

  // Reset values of the state
  localparam logic CQT_QUERY_MODE_RST = 1'b0;
  localparam logic CQT_WE_PREV_RST = 1'b1;
  localparam logic [15:0] CQT_DQ_RST = 16'h0000;
  localparam logic CQT_DQ_OE_RST = 1'b0;
endpackage : cqt_pkg
`default_nettype wire

// ===== cqt_query_table_rom.sv
`timescale 1ns/100ps
`default_nettype none
module cqt_query_table_rom #(
  parameter int ADDR_W = cqt_pkg::CQT_ADDR_W,
  parameter logic [15:0] CMDSET_CODE = cqt_pkg::CQT_CMDSET_CODE_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Flash bus controls, active low
  input wire logic chip_en_n_i,
  input wire logic out_en_n_i,
  input wire logic write_en_n_i,
  // Flash bus address and write data
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [cqt_pkg::CQT_DATA_W-1:0] dq_i,
  // Array read data from the memory core
  input wire logic [cqt_pkg::CQT_DATA_W-1:0] array_data_i,
  // Flash bus read data
  output logic [cqt_pkg::CQT_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  // Mode indication
  output logic query_mode_o
);
  import cqt_pkg::*;

  typedef struct packed {
    logic query_mode;
    logic we_prev;
    logic [CQT_DATA_W-1:0] dq;
    logic dq_oe;
  } cqt_state_type;

  cqt_state_type state_r;
  cqt_state_type state_nxt;

  // Vendor space: no standard field may appear here
  function automatic logic cqt_in_vendor(
    input logic [7:0] ofs
  );
    logic hit;
    hit = 1'b0;
    if ((ofs >= CQT_VENDOR_FIRST_OFS) && (ofs <= CQT_VENDOR_LAST_OFS)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : cqt_in_vendor

  // Identification section runs up to the system interface
  function automatic logic cqt_in_ident(
    input logic [7:0] ofs
  );
    logic hit;
    hit = 1'b0;
    if ((ofs >= CQT_IDENT_SECT_OFS) && (ofs < CQT_SYSIF_SECT_OFS)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : cqt_in_ident

  // System interface section runs up to the geometry
  function automatic logic cqt_in_sysif(
    input logic [7:0] ofs
  );
    logic hit;
    hit = 1'b0;
    if ((ofs >= CQT_SYSIF_SECT_OFS) && (ofs < CQT_GEOM_SECT_OFS)) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : cqt_in_sysif

  // Geometry section and everything above it
  function automatic logic cqt_in_geom(
    input logic [7:0] ofs
  );
    logic hit;
    hit = 1'b0;
    if (ofs >= CQT_GEOM_SECT_OFS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction : cqt_in_geom

  // Command code sits on the low data lines; upper lines ignored
  function automatic logic cqt_cmd_is(
    input logic [CQT_DATA_W-1:0] data,
    input logic [7:0] code
  );
    logic hit;
    hit = (data[7:0] == code);
    return hit;
  endfunction : cqt_cmd_is

  // Signature characters spelling the query string
  function automatic logic [7:0] cqt_sig_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      QUERY_SIG_CHAR_Q_OFS: begin
        b = QUERY_SIG_CHAR_Q_VAL;
      end
      QUERY_SIG_CHAR_R_OFS: begin
        b = QUERY_SIG_CHAR_R_VAL;
      end
      QUERY_SIG_CHAR_Y_OFS: begin
        b = QUERY_SIG_CHAR_Y_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_sig_byte

  // Command-set codes, low byte at the lower offset
  function automatic logic [7:0] cqt_code_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      PRIMARY_CMDSET_CODE_LO_OFS: begin
        b = CMDSET_CODE[7:0];
      end
      PRIMARY_CMDSET_CODE_HI_OFS: begin
        b = CMDSET_CODE[15:8];
      end
      ALT_CMDSET_CODE_LO_OFS: begin
        b = ALT_CMDSET_CODE_LO_VAL;
      end
      ALT_CMDSET_CODE_HI_OFS: begin
        b = ALT_CMDSET_CODE_HI_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_code_byte

  // Extended table pointers, low byte at the lower offset
  function automatic logic [7:0] cqt_ptr_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      EXT_TABLE_ADDR_LO_OFS: begin
        b = EXT_TABLE_ADDR_LO_VAL;
      end
      EXT_TABLE_ADDR_HI_OFS: begin
        b = EXT_TABLE_ADDR_HI_VAL;
      end
      SECOND_TABLE_ADDR_LO_OFS: begin
        b = SECOND_TABLE_ADDR_LO_VAL;
      end
      SECOND_TABLE_ADDR_HI_OFS: begin
        b = SECOND_TABLE_ADDR_HI_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_ptr_byte

  // Core supply limits, BCD volts and tenths
  function automatic logic [7:0] cqt_core_volt_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      CORE_SUPPLY_MIN_VOLT_OFS: begin
        b = CORE_SUPPLY_MIN_VOLT_VAL;
      end
      CORE_SUPPLY_MAX_VOLT_OFS: begin
        b = CORE_SUPPLY_MAX_VOLT_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_core_volt_byte

  // Programming supply limits, hex volts and BCD tenths
  function automatic logic [7:0] cqt_prog_volt_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      PROG_SUPPLY_MIN_VOLT_OFS: begin
        b = PROG_SUPPLY_MIN_VOLT_VAL;
      end
      PROG_SUPPLY_MAX_VOLT_OFS: begin
        b = PROG_SUPPLY_MAX_VOLT_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_prog_volt_byte

  // Typical time-outs as powers of two
  function automatic logic [7:0] cqt_typ_time_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      TYP_WORD_PROG_EXP_OFS: begin
        b = TYP_WORD_PROG_EXP_VAL;
      end
      TYP_BUFFER_WRITE_EXP_OFS: begin
        b = TYP_BUFFER_WRITE_EXP_VAL;
      end
      TYP_BLOCK_ERASE_EXP_OFS: begin
        b = TYP_BLOCK_ERASE_EXP_VAL;
      end
      TYP_CHIP_ERASE_EXP_OFS: begin
        b = TYP_CHIP_ERASE_EXP_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_typ_time_byte

  // Maximum time-outs as multipliers of the typical ones
  function automatic logic [7:0] cqt_max_time_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    case (ofs)
      MAX_WORD_PROG_EXP_OFS: begin
        b = MAX_WORD_PROG_EXP_VAL;
      end
      MAX_BUFFER_WRITE_EXP_OFS: begin
        b = MAX_BUFFER_WRITE_EXP_VAL;
      end
      MAX_BLOCK_ERASE_EXP_OFS: begin
        b = MAX_BLOCK_ERASE_EXP_VAL;
      end
      MAX_CHIP_ERASE_EXP_OFS: begin
        b = MAX_CHIP_ERASE_EXP_VAL;
      end
      default: begin
        b = CQT_UNUSED_VAL;
      end
    endcase
    return b;
  endfunction : cqt_max_time_byte

  // Identification section: string, codes and table pointers
  function automatic logic [7:0] cqt_ident_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    // Helpers give zero outside their own offsets, so OR merges them
    b = cqt_sig_byte(ofs) | cqt_code_byte(ofs) | cqt_ptr_byte(ofs);
    return b;
  endfunction : cqt_ident_byte

  // System interface section: supplies and time-out exponents
  function automatic logic [7:0] cqt_sysif_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = cqt_core_volt_byte(ofs) | cqt_prog_volt_byte(ofs) |
      cqt_typ_time_byte(ofs) | cqt_max_time_byte(ofs);
    return b;
  endfunction : cqt_sysif_byte

  // Section select first, so no field can leak into another section
  function automatic logic [7:0] cqt_table_byte(
    input logic [7:0] ofs
  );
    logic [7:0] b;
    b = CQT_UNUSED_VAL;
    if (cqt_in_vendor(ofs)) begin
      b = CQT_UNUSED_VAL;
    end else if (cqt_in_ident(ofs)) begin
      b = cqt_ident_byte(ofs);
    end else if (cqt_in_sysif(ofs)) begin
      b = cqt_sysif_byte(ofs);
    end else if (cqt_in_geom(ofs)) begin
      // Geometry bytes are held outside this block
      b = CQT_UNUSED_VAL;
    end else begin
      b = CQT_UNUSED_VAL;
    end
    return b;
  endfunction : cqt_table_byte

  // Constant image of the offset space; block address bits ignored
  localparam int TABLE_DEPTH = 2 ** CQT_OFS_W;
  logic [7:0] table_rom [TABLE_DEPTH];

  // One generated entry per offset; no write path reaches them
  for (genvar i = 0; i < TABLE_DEPTH; i++) begin : g_rom
    assign table_rom[i] = cqt_table_byte(8'(i));
  end

  logic bus_sel;
  logic rd_req;
  logic wr_edge;
  logic cmd_query;
  logic cmd_read_array;
  logic [7:0] ofs;
  logic [CQT_DATA_W-1:0] query_word;

  // Bus decode; a write is taken on the cycle write enable falls
  assign bus_sel = !chip_en_n_i;
  assign rd_req = bus_sel && !out_en_n_i && write_en_n_i;
  assign wr_edge = bus_sel && !write_en_n_i && state_r.we_prev;
  assign ofs = addr_i[7:0];

  // Mode commands; any other code is dropped without effect
  assign cmd_query = wr_edge && cqt_cmd_is(dq_i, CQT_CMD_QUERY);
  assign cmd_read_array = wr_edge && cqt_cmd_is(dq_i, CQT_CMD_READ_ARRAY);

  // Query word: table byte low, upper data lines held at zero
  assign query_word = {CQT_UPPER_BYTE_VAL, table_rom[ofs]};

  // Next state
  always_comb begin
    state_nxt = state_r;
    state_nxt.we_prev = write_en_n_i;
    // Only mode commands act; no write path reaches the table
    if (cmd_query) begin
      state_nxt.query_mode = 1'b1;
    end else if (cmd_read_array) begin
      state_nxt.query_mode = 1'b0;
    end
    // Read data registered so outputs come from flops
    state_nxt.dq_oe = rd_req;
    if (!rd_req) begin
      state_nxt.dq = CQT_DQ_RST;
    end else if (state_r.query_mode) begin
      state_nxt.dq = query_word;
    end else begin
      state_nxt.dq = array_data_i;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r.query_mode <= CQT_QUERY_MODE_RST;
      state_r.we_prev <= CQT_WE_PREV_RST;
      state_r.dq <= CQT_DQ_RST;
      state_r.dq_oe <= CQT_DQ_OE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign dq_o = state_r.dq;
  assign dq_oe_o = state_r.dq_oe;
  assign query_mode_o = state_r.query_mode;
endmodule : cqt_query_table_rom
`default_nettype wire

// ===== cqt_query_table_rom_tb.sv
`timescale 1ns/100ps
`default_nettype none
module cqt_query_table_rom_tb;
  logic clk = 0, rst = 1, ce_n, oe_n, we_n, oe, qm;
  logic [22:0] addr;
  logic [15:0] wd, dq, d, arr = 16'h1234;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  logic [7:0] tbl [23] = '{8'h51, 8'h52, 8'h59, 8'ha5, 8'hc3, 8'h0a, 8'h01,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h17, 8'h20, 8'h85, 8'h95, 8'h08, 8'h09,
    8'h0a, 8'h00, 8'h01, 8'h01, 8'h02, 8'h00};
  always #50 clk = ~clk;
  cqt_host u_host (.clk_i(clk), .rdata_i(dq), .ce_n_o(ce_n), .oe_n_o(oe_n),
    .we_n_o(we_n), .addr_o(addr), .wdata_o(wd));
  cqt_query_table_rom #(.CMDSET_CODE(16'hc3a5)) DUT (.clk_i(clk), .rst_i(rst),
    .chip_en_n_i(ce_n), .out_en_n_i(oe_n), .write_en_n_i(we_n),
    .addr_i(addr), .dq_i(wd), .array_data_i(arr), .dq_o(dq),
    .dq_oe_o(oe), .query_mode_o(qm));
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Hang guard, nearly five times the expected run of about 85 cycles
  always @(posedge clk) if (++cyc > 400) begin
    error_cnt++;
    final_report();
  end
  // Array read, full table walk, stray writes, exit
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    u_host.rd(8'h10, d);
    chk("array", 16'h1234, d);
    u_host.wr(8'h00, 8'h98);
    chk("mode", 16'h0001, {15'h0, qm});
    for (int i = 0; i < 23; i++) begin
      u_host.rd(8'h10 + i[7:0], d);
      chk("table", {8'h00, tbl[i]}, d);
    end
    u_host.rd(8'h01, d);
    chk("vendor", 16'h0000, d);
    u_host.rd(8'h0f, d);
    chk("vendor", 16'h0000, d);
    $display("query table test done");
    u_host.wr(8'h10, 8'h00);
    u_host.wr(8'h10, 8'h40);
    u_host.rd(8'h10, d);
    chk("after write", 16'h0051, d);
    chk("mode kept", 16'h0001, {15'h0, qm});
    u_host.wr(8'h00, 8'hff);
    arr = 16'hbeef;
    u_host.rd(8'h10, d);
    chk("array back", 16'hbeef, d);
    // Enable drops one edge after the read is released
    @(posedge clk);
    #1;
    chk("oe off", 16'h0000, {15'h0, oe});
    $display("mode exit test done");
    final_report();
  end
endmodule : cqt_query_table_rom_tb
`default_nettype wire
